// [hdl/pofp_cmd_regs.sv]
`timescale 1ns/1ps
// Function
// - Hot output only when select equals 01
// - Power-up bit fixed one, read-only
// - Command-response bit gates operation on bit
// - Enable-pin-response bit gates enable pin
// - Polarity bit fixed one, pin active high
// - Speed bit fixed one, immediate shutdown
// - Fault clear never restarts latched output
// - Fault clear is a bare command code
// - Invalid lock byte flags comm and data
// - Invalid lock byte means no protection
// - Lock byte resets zero, low five zero
// - Output on needs vin, no latch-off, a response bit set, and on bit/pin for each one set
// - Only four lock bytes are valid
module pofp_cmd_regs
   import pofp_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire pofp_cmd_s i_cmd,
   input wire logic i_enable_pin,
   input wire logic i_vin_ok,
   input wire logic i_iin_oc_warn,
   input wire logic [7:0] i_fault_present,
   input wire logic i_fault_latch_off,
   output logic [7:0] o_rd_data,
   output logic o_wr_refused,
   output logic [7:0] o_fault_bits,
   output logic o_comm_error_flag,
   output logic o_unsupported_data_flag,
   output logic o_alert_output,
   output logic o_regulator_hot_output,
   output logic o_output_on
);
   // ----------------------------------------------------------------
   // Lock byte check
   // ----------------------------------------------------------------
   function automatic logic lock_valid(input logic [7:0] b);
      lock_valid = (b == WLOCK_ALL) || (b == WLOCK_OP) ||
         (b == WLOCK_CFG) || (b == WLOCK_NONE);
   endfunction

   logic [7:0] operation; // Operation byte
   logic [7:0] onoff_cfg; // Writable config bits only
   logic [7:0] wlock; // Active lock level
   logic latched_off; // Output latched off by a fault

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire is_op = i_cmd.code == CMD_OPERATION;
   wire is_cfg = i_cmd.code == CMD_OUTPUT_ON_CONTROL_CONFIG;
   wire is_lock = i_cmd.code == CMD_WRITE_LOCK_LEVEL;
   // Lock ALL passes only lock writes, OP adds operation, CFG adds cfg
   wire wr_allowed = is_lock || (wlock == WLOCK_NONE) ||
      (is_op && wlock != WLOCK_ALL) ||
      (is_cfg && wlock == WLOCK_CFG);
   wire wr_ok = i_cmd.wr && wr_allowed;
   wire clear_cmd = i_cmd.send && i_cmd.code == CMD_FAULT_CLEAR;
   wire lock_bad = wr_ok && is_lock && !lock_valid(i_cmd.data);
   wire [7:0] cfg_view = onoff_cfg | ONOFF_FIXED;
   wire [7:0] next_rd = is_op ? operation :
      is_cfg ? cfg_view :
      is_lock ? wlock : 8'h00;

   assign o_wr_refused = i_cmd.wr && !wr_allowed;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Writes keep only the writable bits
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         operation <= OPERATION_RST;
         onoff_cfg <= ONOFF_RST & ONOFF_WR_MASK;
         wlock <= WLOCK_RST;
      end else if (wr_ok) begin
         if (is_op) begin
            operation <= i_cmd.data & OPERATION_WR_MASK;
         end
         if (is_cfg) begin
            onoff_cfg <= i_cmd.data & ONOFF_WR_MASK;
         end
         if (is_lock) begin
            // Invalid bytes leave no protection
            wlock <= lock_valid(i_cmd.data) ?
               (i_cmd.data & WLOCK_WR_MASK) : WLOCK_NONE;
         end
      end
   end

   // Read data register
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rd_data <= 8'h00;
      end else if (i_cmd.rd) begin
         o_rd_data <= next_rd;
      end
   end

   // ----------------------------------------------------------------
   // Faults, status and alert
   // ----------------------------------------------------------------
   // Clear wipes all, yet a present fault sets again the same cycle
   wire [7:0] next_faults = (clear_cmd ? 8'h00 : o_fault_bits) |
      i_fault_present;
   wire next_cml = (o_comm_error_flag && !clear_cmd) || lock_bad;
   wire next_usd = (o_unsupported_data_flag && !clear_cmd) || lock_bad;
   wire next_alert = (|next_faults) || next_cml;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_fault_bits <= 8'h00;
         o_comm_error_flag <= 1'b0;
         o_unsupported_data_flag <= 1'b0;
         o_alert_output <= 1'b0;
      end else begin
         o_fault_bits <= next_faults;
         o_comm_error_flag <= next_cml;
         o_unsupported_data_flag <= next_usd;
         o_alert_output <= next_alert;
      end
   end

   // Latch-off survives fault clear, only reset releases it
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         latched_off <= 1'b0;
      end else if (i_fault_latch_off) begin
         latched_off <= 1'b1;
      end
   end

   // Hot output follows warning when select is 01
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_regulator_hot_output <= 1'b0;
      end else begin
         o_regulator_hot_output <= i_iin_oc_warn &&
            (operation[1:0] == HOT_SEL_ON);
      end
   end

   // ----------------------------------------------------------------
   // Output enable
   // ----------------------------------------------------------------
   pofp_enable_logic i_pofp_enable_logic (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_on_bit(operation[OP_ON_BIT]),
      .i_cmd_resp(onoff_cfg[ONOFF_CMD_BIT]),
      .i_pin_resp(onoff_cfg[ONOFF_PIN_BIT]),
      .i_enable_pin(i_enable_pin),
      .i_vin_ok(i_vin_ok),
      .i_latched_off(latched_off),
      .o_output_on(o_output_on)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Hot output never rises unless the select held 01 an edge before
   chk_hot_select: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      o_regulator_hot_output |-> $past(operation[1:0]) == 2'h1)
      else $error("hot output with wrong select");
   // A warning with select 01 must raise the hot output next edge
   chk_hot_follow: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_iin_oc_warn && operation[1:0] == HOT_SEL_ON) |=>
      o_regulator_hot_output)
      else $error("hot output missing");
   // A config read returns the fixed bits whatever was written
   chk_cfg_fixed: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_cmd.rd && is_cfg) |=> (o_rd_data & 8'hf3) == ONOFF_FIXED)
      else $error("config fixed bits wrong");
   // Command response set and on bit clear keeps the output off
   chk_cmd_ignore: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (onoff_cfg[3] && !operation[7]) |=> !o_output_on)
      else $error("on bit ignored");
   // Pin response set and pin low keeps the output off
   chk_pin_ignore: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (onoff_cfg[2] && !i_enable_pin) |=> !o_output_on)
      else $error("enable pin ignored");
   // Pin-only control turns on with the pin high
   chk_pin_high: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_vin_ok && onoff_cfg[3:2] == 2'h1 && i_enable_pin && !latched_off)
      |=> o_output_on)
      else $error("pin not active high");
   // Loss of input voltage drops the output at the next edge
   chk_fast_off: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      !i_vin_ok |=> !o_output_on)
      else $error("shutdown not immediate");
   // A clear with nothing present wipes every flag and the alert
   chk_clear_all: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (clear_cmd && i_fault_present == 8'h00) |=>
      o_fault_bits == 8'h00 && !o_comm_error_flag &&
      !o_unsupported_data_flag && !o_alert_output)
      else $error("clear left flags");
   // A latched output stays off whatever else happens
   chk_latch_stay: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      latched_off |=> !o_output_on)
      else $error("latched output restarted");
   // A fault still present keeps or brings back the alert
   chk_fault_again: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_fault_present != 8'h00) |=> o_alert_output)
      else $error("present fault not alerted");
   // An invalid lock byte raises both flags and drops protection
   chk_lock_bad: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      lock_bad |=> o_comm_error_flag && o_unsupported_data_flag &&
      wlock == 8'h00)
      else $error("invalid lock not handled");
   // The stored lock level is always one of the legal bytes
   chk_lock_low: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      wlock[4:0] == 5'h00 && lock_valid(wlock))
      else $error("lock byte illegal");
   // Lock reads return zeros in the reserved low bits
   chk_lock_read: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_cmd.rd && is_lock) |=> o_rd_data[4:0] == 5'h00)
      else $error("lock reserved bits not zero");
   // A refused write leaves every register as it was
   chk_refused_keep: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      o_wr_refused |=> $stable(operation) && $stable(onoff_cfg) &&
      $stable(wlock))
      else $error("refused write changed a register");
endmodule

// [hdl/pofp_enable_logic.sv]
`timescale 1ns/1ps
module pofp_enable_logic
   import pofp_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_on_bit,
   input wire logic i_cmd_resp,
   input wire logic i_pin_resp,
   input wire logic i_enable_pin,
   input wire logic i_vin_ok,
   input wire logic i_latched_off,
   output logic o_output_on
);
   // ----------------------------------------------------------------
   // Enable decision
   // ----------------------------------------------------------------
   // Pin is active high; command path needs on bit and command response
   wire pin_ok = !i_pin_resp || i_enable_pin;
   wire cmd_ok = !i_cmd_resp || i_on_bit;
   wire cmd_en = i_cmd_resp || i_pin_resp;
   wire next_output_on = i_vin_ok && pin_ok && cmd_ok && cmd_en &&
      !i_latched_off;

   // Evaluated every cycle, drop is immediate with no ramp
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_output_on <= 1'b0;
      end else begin
         o_output_on <= next_output_on;
      end
   end
endmodule

// [hdl/pofp_pkg.sv]
package pofp_pkg;
   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_OPERATION = 8'h01;
   localparam logic [7:0] CMD_OUTPUT_ON_CONTROL_CONFIG = 8'h02;
   localparam logic [7:0] CMD_FAULT_CLEAR = 8'h03;
   localparam logic [7:0] CMD_WRITE_LOCK_LEVEL = 8'h10;
   // ----------------------------------------------------------------
   // Reset values and fixed bits
   // ----------------------------------------------------------------
   localparam logic [7:0] OPERATION_RST = 8'h00;
   localparam logic [7:0] ONOFF_RST = 8'h17;
   localparam logic [7:0] ONOFF_FIXED = 8'h13;
   localparam logic [7:0] ONOFF_WR_MASK = 8'h0c;
   localparam logic [7:0] OPERATION_WR_MASK = 8'hbf;
   localparam logic [7:0] WLOCK_RST = 8'h00;
   localparam logic [7:0] WLOCK_WR_MASK = 8'he0;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int OP_ON_BIT = 7;
   localparam int ONOFF_CMD_BIT = 3;
   localparam int ONOFF_PIN_BIT = 2;
   localparam logic [1:0] HOT_SEL_ON = 2'h1;
   // ----------------------------------------------------------------
   // Valid write lock bytes
   // ----------------------------------------------------------------
   localparam logic [7:0] WLOCK_ALL = 8'h80;
   localparam logic [7:0] WLOCK_OP = 8'h40;
   localparam logic [7:0] WLOCK_CFG = 8'h20;
   localparam logic [7:0] WLOCK_NONE = 8'h00;
   // ----------------------------------------------------------------
   // Command strobe carrier
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic send;
      logic [7:0] code;
      logic [7:0] data;
   } pofp_cmd_s;
endpackage

// [tb/pofp_cmd_regs_bench.sv]
`timescale 1ns/1ps
module pofp_cmd_regs_bench
   import pofp_pkg::*;
;
   // ----------------------------------------------------------------
   // Stimulus, observed outputs and tables
   // ----------------------------------------------------------------
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   pofp_cmd_s cmd;
   logic en_pin = 1'b0;
   logic vin_ok = 1'b0;
   logic oc_warn = 1'b0;
   logic [7:0] flt = 8'h00;
   logic latch = 1'b0;
   logic [7:0] rd_data, fault_bits;
   logic refused, comm_err, unsup_data, alert, hot, out_on;
   int err_count = 0;
   int cmp_count = 0;
   logic [7:0] locks [4] = '{8'h80, 8'h40, 8'h20, 8'h00};
   logic [7:0] bad [3] = '{8'h81, 8'h1f, 8'he0};
   // 10 MHz clock
   always #50 ref_clk = ~ref_clk;
   pofp_cmd_regs i_pofp_cmd_regs (.i_ref_clk(ref_clk), .i_rst(rst),
      .i_cmd(cmd), .i_enable_pin(en_pin), .i_vin_ok(vin_ok),
      .i_iin_oc_warn(oc_warn), .i_fault_present(flt),
      .i_fault_latch_off(latch), .o_rd_data(rd_data),
      .o_wr_refused(refused), .o_fault_bits(fault_bits),
      .o_comm_error_flag(comm_err), .o_unsupported_data_flag(unsup_data),
      .o_alert_output(alert), .o_regulator_hot_output(hot),
      .o_output_on(out_on));
   pofp_host_model i_pofp_host_model (.i_ref_clk(ref_clk),
      .i_rd_data(rd_data), .i_wr_refused(refused), .o_cmd(cmd));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   // Single compare point: counts the compare and reports a mismatch
   task automatic check(input logic [7:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t ns: %h not %h", $time, seen, exp);
      end
   endtask
   // Write one byte and compare the refusal seen with the one expected
   task automatic wr(input logic [7:0] c, d, input logic exp_ref);
      logic [7:0] r;
      logic f;
      i_pofp_host_model.issue(3'b100, c, d, r, f);
      check({7'h0, f}, {7'h0, exp_ref});
   endtask
   // Read one byte and compare it with the expected value
   task automatic rd(input logic [7:0] c, exp);
      logic [7:0] r;
      logic f;
      i_pofp_host_model.issue(3'b010, c, 8'h00, r, f);
      check(r, exp);
   endtask
   // Send the bare fault clear command code
   task automatic clr();
      logic [7:0] r;
      logic f;
      i_pofp_host_model.issue(3'b001, CMD_FAULT_CLEAR, 8'h00, r, f);
   endtask
   task automatic wait2();
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   // Let the enable decision settle, then compare the output state
   task automatic settle(input logic exp_on);
      wait2();
      check({7'h0, out_on}, {7'h0, exp_on});
   endtask
   task automatic report_and_stop();
      $display("compares %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge ref_clk);
      #1 rst = 1'b0;
      rd(CMD_OUTPUT_ON_CONTROL_CONFIG, 8'h17);
      rd(CMD_WRITE_LOCK_LEVEL, 8'h00);
      wr(CMD_OUTPUT_ON_CONTROL_CONFIG, 8'hff, 1'b0);
      rd(CMD_OUTPUT_ON_CONTROL_CONFIG, 8'h1f);
      vin_ok = 1'b1;
      en_pin = 1'b1;
      settle(1'b0);
      wr(CMD_OPERATION, 8'h80, 1'b0);
      settle(1'b1);
      en_pin = 1'b0;
      settle(1'b0);
      wr(CMD_OUTPUT_ON_CONTROL_CONFIG, 8'h08, 1'b0);
      settle(1'b1);
      vin_ok = 1'b0;
      settle(1'b0);
      vin_ok = 1'b1;
      wr(CMD_OUTPUT_ON_CONTROL_CONFIG, 8'h04, 1'b0);
      wr(CMD_OPERATION, 8'h00, 1'b0);
      en_pin = 1'b1;
      settle(1'b1);
      // Hot output follows the warning only for select 01
      oc_warn = 1'b1;
      for (int s = 0; s < 4; s++) begin
         wr(CMD_OPERATION, 8'(s), 1'b0);
         wait2();
         check({7'h0, hot}, {7'h0, s == 1});
      end
      oc_warn = 1'b0;
      // Sticky faults, clearing, and refill while a fault persists
      flt = 8'h04;
      wait2();
      flt = 8'h00;
      wait2();
      check({fault_bits[6:0], alert}, 8'h09);
      clr();
      wait2();
      check({fault_bits[6:0], alert}, 8'h00);
      flt = 8'h04;
      clr();
      wait2();
      check({fault_bits[6:0], alert}, 8'h09);
      flt = 8'h00;
      clr();
      // Invalid lock bytes flag errors and drop all protection
      foreach (bad[i]) begin
         wr(CMD_WRITE_LOCK_LEVEL, 8'h80, 1'b0);
         wr(CMD_WRITE_LOCK_LEVEL, bad[i], 1'b0);
         wait2();
         check({5'h0, comm_err, unsup_data, alert}, 8'h07);
         wr(CMD_OUTPUT_ON_CONTROL_CONFIG, 8'h04, 1'b0);
         clr();
         wait2();
         check({5'h0, comm_err, unsup_data, alert}, 8'h00);
      end
      // Each valid lock level and the writes it blocks
      foreach (locks[i]) begin
         wr(CMD_WRITE_LOCK_LEVEL, locks[i], 1'b0);
         rd(CMD_WRITE_LOCK_LEVEL, locks[i]);
         wr(CMD_OPERATION, 8'h01, locks[i] == 8'h80);
         rd(CMD_OPERATION, (locks[i] == 8'h80) ? 8'h03 : 8'h01);
         wr(CMD_OUTPUT_ON_CONTROL_CONFIG, 8'h04, |locks[i][7:6]);
         check({7'h0, comm_err}, 8'h00);
      end
      // Latched-off output stays off through a fault clear
      settle(1'b1);
      latch = 1'b1;
      @(posedge ref_clk);
      #1 latch = 1'b0;
      settle(1'b0);
      clr();
      settle(1'b0);
      // Only a reset frees a latched output, defaults return with it
      rst = 1'b1;
      wait2();
      rst = 1'b0;
      rd(CMD_OUTPUT_ON_CONTROL_CONFIG, 8'h17);
      rd(CMD_WRITE_LOCK_LEVEL, 8'h00);
      settle(1'b1);
      report_and_stop();
   end
   // Watchdog at 2000 cycles, far beyond the under two hundred cycles the tests need
   initial begin
      #200000;
      err_count++;
      report_and_stop();
   end
endmodule

// [tb/pofp_host_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host side of the command interface
// ----------------------------------------------------------------
module pofp_host_model
   import pofp_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic [7:0] i_rd_data,
   input wire logic i_wr_refused,
   output pofp_cmd_s o_cmd
);
   // Idle bus: no strobe, no code, no data
   initial o_cmd = '0;
   // One strobe held across exactly one rising edge; kind is wr,rd,send
   // A write carries one data byte, a bare command carries none
   task automatic issue(input logic [2:0] kind, input logic [7:0] code,
      input logic [7:0] data, output logic [7:0] rd, output logic ref_seen);
      @(posedge i_ref_clk);
      #1;
      o_cmd = {kind, code, kind[2] ? data : 8'h00};
      #10 ref_seen = i_wr_refused;
      @(posedge i_ref_clk);
      #1;
      o_cmd = '0;
      rd = i_rd_data;
   endtask
endmodule
